// *** src/touch_key_status_interrupt.sv ***
// touch-key register file, change tracking, interrupt and serial slave
`timescale 1ns/1ns
module touch_key_status_interrupt #(
    parameter logic [19:0] AUTOCLR_SHORT_CYC = 20'(touch_key_pkg::AUTOCLR_SHORT_CYC),
    parameter logic [19:0] AUTOCLR_LONG_CYC  = 20'(touch_key_pkg::AUTOCLR_LONG_CYC)
) (
    // system clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // serial link (clocked by its own sampling clock)
    input  wire logic       clk_link_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [1:0] addr_sel_i,
    // sensing front end
    input  wire logic [7:0] touch_raw_i,
    input  wire logic       hw_shutdown_n_i,
    output logic      [1:0] sense_sel_o,
    output logic            sleep_o,
    // channel sink outputs and interrupt
    output logic      [7:0] chan_out_o,
    output logic      [7:0] chan_oe_o,
    output logic            irq_out_n_o
);

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef struct packed {
        touch_key_pkg::link_state_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic       rw;
        logic [7:0] ptr;
        logic [7:0] tx;
        logic       sda_oe;
        logic       scl_d;
        logic       sda_d;
        logic       wr_tog;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic       rd_tog;
        logic       ack_seen;
        logic [1:0] strap;
    } link_t;

    typedef struct packed {
        logic       soft_sd;
        logic [1:0] sense;
        logic [7:0] en;
        logic [7:0] pressed;
        logic [7:0] change;
        logic [1:0] irq_autoclear_select;
        logic       irq_n;
        logic [19:0] cnt;
        logic       wr_seen;
        logic       rd_seen;
        logic [7:0] rd_data;
        logic       rd_ack;
        logic       sleep;
    } sys_t;

    link_t l_r;
    link_t l_nxt;
    sys_t  s_r;
    sys_t  s_nxt;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [3:0]  link_in;
    logic [10:0] sys_in;
    logic        lrst;
    logic        ack_f;
    logic        scl_f;
    logic        sda_f;
    logic        hw_n_f;
    logic [7:0]  touch_f;
    logic        wr_f;
    logic        rd_f;

    sync3 #(.WIDTH(4)) u_link_sync (
        .clk_i   (clk_link_i),
        .async_i ({reset_i, s_r.rd_ack, scl_i, sda_i}),
        .sync_o  (link_in)
    );

    sync3 #(.WIDTH(11)) u_sys_sync (
        .clk_i   (clk_sys_i),
        .async_i ({hw_shutdown_n_i, touch_raw_i, l_r.wr_tog, l_r.rd_tog}),
        .sync_o  (sys_in)
    );

    assign {lrst, ack_f, scl_f, sda_f} = link_in;
    assign {hw_n_f, touch_f, wr_f, rd_f} = sys_in;

    // ------------------------------------------------------------
    // link domain: serial slave
    // ------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_f & ~l_r.scl_d;
    assign scl_fall  = ~scl_f & l_r.scl_d;
    assign bus_start = scl_f & l_r.scl_d & l_r.sda_d & ~sda_f;
    assign bus_stop  = scl_f & l_r.scl_d & ~l_r.sda_d & sda_f;

    // byte sequencer; read data come back over a toggle handshake
    always_comb begin
        l_nxt       = l_r;
        l_nxt.scl_d = scl_f;
        l_nxt.sda_d = sda_f;
        // rd_data is stable once the answer toggle has crossed
        if (ack_f != l_r.ack_seen) begin
            l_nxt.ack_seen = ack_f;
            l_nxt.tx       = s_r.rd_data;
        end
        if (lrst) begin
            l_nxt       = '0;
            l_nxt.strap = addr_sel_i;                  // strap caught while in reset
            l_nxt.scl_d = 1'b1;
            l_nxt.sda_d = 1'b1;
        end else if (bus_start) begin
            // a repeated start re-enters address phase, pointer kept
            l_nxt.st     = touch_key_pkg::L_ADDR;
            l_nxt.cnt    = 4'h0;
            l_nxt.sda_oe = 1'b0;
        end else if (bus_stop) begin
            l_nxt.st     = touch_key_pkg::L_IDLE;
            l_nxt.sda_oe = 1'b0;
        end else begin
            unique case (l_r.st)
                touch_key_pkg::L_IDLE: begin
                end
                touch_key_pkg::L_ADDR,
                touch_key_pkg::L_REG,
                touch_key_pkg::L_WDATA: begin
                    if (scl_rise) begin
                        l_nxt.sh  = {l_r.sh[6:0], sda_f};
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end
                    if (scl_fall && l_r.cnt == 4'h8) begin
                        l_nxt.cnt    = 4'h0;
                        l_nxt.sda_oe = 1'b1;
                        if (l_r.st == touch_key_pkg::L_ADDR) begin
                            if (l_r.sh[7:1] == {touch_key_pkg::BUS_ADDR_HI, l_r.strap}) begin
                                l_nxt.rw = l_r.sh[0];
                                l_nxt.st = touch_key_pkg::L_ADDR_ACK;
                                // fetch early; ack phase leaves ample time
                                if (l_r.sh[0]) begin
                                    l_nxt.rd_tog = ~l_r.rd_tog;
                                end
                            end else begin
                                l_nxt.sda_oe = 1'b0;
                                l_nxt.st     = touch_key_pkg::L_IDLE;
                            end
                        end else if (l_r.st == touch_key_pkg::L_REG) begin
                            l_nxt.ptr = l_r.sh;
                            l_nxt.st  = touch_key_pkg::L_REG_ACK;
                        end else begin
                            l_nxt.wr_addr = l_r.ptr;
                            l_nxt.wr_data = l_r.sh;
                            l_nxt.wr_tog  = ~l_r.wr_tog;
                            l_nxt.st      = touch_key_pkg::L_WDATA_ACK;
                        end
                    end
                end
                touch_key_pkg::L_ADDR_ACK,
                touch_key_pkg::L_REG_ACK,
                touch_key_pkg::L_WDATA_ACK: begin
                    if (scl_fall) begin
                        l_nxt.sda_oe = 1'b0;
                        if (l_r.st == touch_key_pkg::L_ADDR_ACK && l_r.rw) begin
                            l_nxt.st     = touch_key_pkg::L_RDATA;
                            l_nxt.sh     = {l_r.tx[6:0], 1'b0};
                            l_nxt.sda_oe = ~l_r.tx[7];
                        end else if (l_r.st == touch_key_pkg::L_ADDR_ACK) begin
                            l_nxt.st = touch_key_pkg::L_REG;
                        end else begin
                            l_nxt.st = touch_key_pkg::L_WDATA;
                        end
                    end
                end
                touch_key_pkg::L_RDATA: begin
                    if (scl_rise) begin
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (l_r.cnt == 4'h8) begin
                            l_nxt.sda_oe = 1'b0;
                            l_nxt.st     = touch_key_pkg::L_RACK;
                        end else begin
                            l_nxt.sda_oe = ~l_r.sh[7];
                            l_nxt.sh     = {l_r.sh[6:0], 1'b0};
                        end
                    end
                end
                touch_key_pkg::L_RACK: begin
                    // master nack ends the read; ack repeats the fetched byte
                    if (scl_rise && sda_f) begin
                        l_nxt.st = touch_key_pkg::L_IDLE;
                    end else if (scl_fall) begin
                        l_nxt.st     = touch_key_pkg::L_RDATA;
                        l_nxt.cnt    = 4'h0;
                        l_nxt.sh     = {l_r.tx[6:0], 1'b0};
                        l_nxt.sda_oe = ~l_r.tx[7];
                    end
                end
                default: begin
                    l_nxt.st     = touch_key_pkg::L_IDLE;
                    l_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_link_i) begin
        l_r <= l_nxt;
    end

    // ------------------------------------------------------------
    // system domain: registers, change flags, interrupt
    // ------------------------------------------------------------
    logic        awake;
    logic        wr_ev;
    logic        rd_ev;
    logic        read_clr;
    logic [7:0]  now_pressed;
    logic [7:0]  ev;
    logic [19:0] limit;
    logic [7:0]  rd_mux;

    always_comb begin
        awake       = ~s_r.soft_sd & hw_n_f;
        wr_ev       = wr_f != s_r.wr_seen;
        rd_ev       = rd_f != s_r.rd_seen;
        // the link's held bytes are stable when a toggle arrives
        read_clr    = rd_ev & hw_n_f & (l_r.ptr == touch_key_pkg::REG_CHANGE);
        now_pressed = touch_f & s_r.en;
        // frozen sensing in shutdown keeps pressed as it was and sets no change flag
        ev          = awake ? (now_pressed ^ s_r.pressed) : 8'h00;
        unique case (s_r.irq_autoclear_select)
            touch_key_pkg::AUTOCLR_8MS:  limit = AUTOCLR_SHORT_CYC;
            touch_key_pkg::AUTOCLR_32MS: limit = AUTOCLR_LONG_CYC;
            default:                     limit = 20'h00000;
        endcase
        unique case (l_r.ptr)
            touch_key_pkg::REG_CONFIG:  rd_mux = {s_r.soft_sd, s_r.sense, 5'h00};
            touch_key_pkg::REG_ENABLES: rd_mux = s_r.en;
            touch_key_pkg::REG_PRESSED: rd_mux = s_r.pressed;
            touch_key_pkg::REG_CHANGE:  rd_mux = s_r.change;
            touch_key_pkg::REG_AUTOCLR: rd_mux = {s_r.irq_autoclear_select, 6'h00};
            default:                    rd_mux = 8'h00;
        endcase
    end

    // state update; a new event beats a clearing read in the same cycle
    always_comb begin
        s_nxt         = s_r;
        s_nxt.wr_seen = wr_f;
        s_nxt.rd_seen = rd_f;
        s_nxt.sleep   = ~awake;
        if (awake) begin
            s_nxt.pressed = now_pressed;
        end
        s_nxt.change = (s_r.change & ~{8{read_clr}}) | ev;
        if (|ev) begin
            s_nxt.irq_n = 1'b0;
            s_nxt.cnt   = 20'h00000;
        end else if (read_clr) begin
            s_nxt.irq_n = 1'b1;
            s_nxt.cnt   = 20'h00000;
        end else if (!s_r.irq_n && limit != 20'h00000 && hw_n_f) begin
            if (s_r.cnt >= limit - 20'h00001) begin
                s_nxt.irq_n = 1'b1;
                s_nxt.cnt   = 20'h00000;
            end else begin
                s_nxt.cnt = s_r.cnt + 20'h00001;
            end
        end
        // register writes are dropped while the shutdown pin is low
        if (wr_ev && hw_n_f) begin
            unique case (l_r.wr_addr)
                touch_key_pkg::REG_CONFIG: begin
                    s_nxt.soft_sd = l_r.wr_data[touch_key_pkg::CFG_SHUTDOWN_BIT];
                    s_nxt.sense   = l_r.wr_data[touch_key_pkg::CFG_SENSE_LSB +: 2];
                end
                touch_key_pkg::REG_ENABLES: s_nxt.en = l_r.wr_data;
                touch_key_pkg::REG_AUTOCLR: begin
                    s_nxt.irq_autoclear_select = l_r.wr_data[touch_key_pkg::AUTOCLR_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
        if (rd_ev) begin
            s_nxt.rd_data = rd_mux;
            s_nxt.rd_ack  = ~s_r.rd_ack;
        end
        if (reset_i) begin
            s_nxt         = '0;
            s_nxt.sense   = touch_key_pkg::SENSE_RST;
            s_nxt.en      = touch_key_pkg::ENABLES_RST;
            s_nxt.pressed = touch_key_pkg::PRESSED_RST;
            s_nxt.change  = touch_key_pkg::CHANGE_RST;
            s_nxt.irq_autoclear_select     = touch_key_pkg::AUTOCLR_RST;
            s_nxt.irq_n   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open-drain pins only ever pull low, so the level is fixed
    assign sda_o       = 1'b0;
    assign sda_oe_o    = l_r.sda_oe;
    assign chan_out_o  = 8'h00;
    assign chan_oe_o   = s_r.pressed;
    assign irq_out_n_o = s_r.irq_n;
    assign sense_sel_o = s_r.sense;
    assign sleep_o     = s_r.sleep;

endmodule // touch_key_status_interrupt

// *** src/touch_key_pkg.sv ***
// shared constants and types of the touch-key status and interrupt block
package touch_key_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CONFIG   = 8'h00;
    localparam logic [7:0] REG_ENABLES  = 8'h01;
    localparam logic [7:0] REG_PRESSED  = 8'h02;
    localparam logic [7:0] REG_CHANGE   = 8'h03;
    localparam logic [7:0] REG_AUTOCLR  = 8'h04;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         CFG_SHUTDOWN_BIT = 7;
    localparam int         CFG_SENSE_LSB    = 5;
    localparam int         AUTOCLR_LSB      = 6;
    localparam logic [1:0] SENSE_RST        = 2'h0;
    localparam logic [7:0] ENABLES_RST      = 8'hff;
    localparam logic [7:0] PRESSED_RST      = 8'h00;
    localparam logic [7:0] CHANGE_RST       = 8'h00;
    localparam logic [1:0] AUTOCLR_RST      = 2'h0;

    // sensitivity codes (11 is not a valid setting)
    localparam logic [1:0] SENSE_NORMAL = 2'h0;
    localparam logic [1:0] SENSE_HIGH   = 2'h1;
    localparam logic [1:0] SENSE_LOW    = 2'h2;

    // auto-clear codes (11 is not a valid setting)
    localparam logic [1:0] AUTOCLR_OFF  = 2'h0;
    localparam logic [1:0] AUTOCLR_8MS  = 2'h1;
    localparam logic [1:0] AUTOCLR_32MS = 2'h2;

    // upper five bits of the seven-bit bus address
    localparam logic [4:0] BUS_ADDR_HI = 5'h11;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ        = 25_000_000;
    localparam int unsigned AUTOCLR_SHORT_MS  = 8;
    localparam int unsigned AUTOCLR_LONG_MS   = 32;
    localparam int unsigned AUTOCLR_SHORT_CYC = SYS_CLK_HZ / 1000 * AUTOCLR_SHORT_MS;
    localparam int unsigned AUTOCLR_LONG_CYC  = SYS_CLK_HZ / 1000 * AUTOCLR_LONG_MS;
    localparam int          AUTOCLR_CNT_W     = 20;

    // serial slave sequencer states
    typedef enum logic [3:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_REG, L_REG_ACK,
        L_WDATA, L_WDATA_ACK, L_RDATA, L_RACK
    } link_state_t;

endpackage

// *** src/sync3.sv ***
// three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ns
module sync3 #(
    parameter int WIDTH = 1
) (
    // clock
    input  wire logic             clk_i,
    // asynchronous side
    input  wire logic [WIDTH-1:0] async_i,
    // synchronous side
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] filt;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;
    logic [WIDTH-1:0] agree;

    // ------------------------------------------------------------
    // chain and filter
    // ------------------------------------------------------------
    // s1 feeds only s2; the filter looks at s2 and s3
    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = async_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        agree       = ~(st_r.s2 ^ st_r.s3);
        st_nxt.filt = (agree & st_r.s3) | (~agree & st_r.filt);
    end

    // no reset: pure data path, settles within four edges
    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign sync_o = st_r.filt;

endmodule // sync3

// *** verif/touch_key_assertions.sv ***
// port-level assertions for the touch-key block, bound to its top module
`timescale 1ns/1ns
module touch_key_checker #(
    parameter logic [19:0] AUTOCLR_SHORT_CYC = 20'd200000,
    parameter logic [19:0] AUTOCLR_LONG_CYC  = 20'd800000
) (
    // system side
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    input wire logic       hw_shutdown_n_i,
    input wire logic [1:0] sense_sel_o,
    input wire logic       sleep_o,
    input wire logic [7:0] chan_out_o,
    input wire logic [7:0] chan_oe_o,
    input wire logic       irq_out_n_o,
    // link side
    input wire logic       clk_link_i,
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o
);
    // cycles low since the last event, and cycles since scl last moved
    logic [19:0] low_r;
    logic [7:0]  quiet_r;
    logic        scl_r;
    logic [7:0]  oe_r;
    always_ff @(posedge clk_sys_i) begin
        scl_r   <= scl_i;
        oe_r    <= chan_oe_o;
        quiet_r <= (reset_i || scl_i != scl_r) ? 8'h00 : quiet_r + {7'h0, quiet_r != 8'hff};
        low_r   <= (reset_i || irq_out_n_o || chan_oe_o != oe_r) ? 20'h0 : low_r + 20'h1;
    end
    // shutdown seen for a while; sync lag makes the first cycles uncertain
    sequence s_asleep;
        sleep_o [*3];
    endsequence
    sequence s_pin_low;
        !hw_shutdown_n_i [*6];
    endsequence
    a_reset_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $fell(reset_i) |-> irq_out_n_o && chan_oe_o == 8'h00 && sense_sel_o == 2'h0)
        else $error("outputs not idle after reset");
    a_irq_on_change: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !$stable(chan_oe_o) |-> !irq_out_n_o)
        else $error("state changed without interrupt");
    a_irq_has_cause: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $fell(irq_out_n_o) |-> !$stable(chan_oe_o))
        else $error("interrupt without state change");
    // release needs recent bus traffic or an auto-clear span
    a_irq_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(irq_out_n_o) |-> quiet_r < 8'h40
        || (low_r + 20'd3 >= AUTOCLR_SHORT_CYC && low_r <= AUTOCLR_SHORT_CYC + 20'd3)
        || (low_r + 20'd3 >= AUTOCLR_LONG_CYC && low_r <= AUTOCLR_LONG_CYC + 20'd3))
        else $error("interrupt released without cause");
    a_pin_sleep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_pin_low |-> sleep_o)
        else $error("no sleep with shutdown pin low");
    a_state_frozen: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_asleep |-> $stable(chan_oe_o))
        else $error("state moved in shutdown");
    a_open_drain: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chan_out_o == 8'h00 && sda_o == 1'b0)
        else $error("open-drain level not low");
    a_ack_edge: assert property (@(posedge clk_link_i) disable iff (reset_i)
        $changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
endmodule  // touch_key_checker

bind touch_key_status_interrupt touch_key_checker #(
    .AUTOCLR_SHORT_CYC(AUTOCLR_SHORT_CYC), .AUTOCLR_LONG_CYC(AUTOCLR_LONG_CYC)
) u_checker (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .hw_shutdown_n_i(hw_shutdown_n_i),
    .sense_sel_o(sense_sel_o), .sleep_o(sleep_o), .chan_out_o(chan_out_o),
    .chan_oe_o(chan_oe_o), .irq_out_n_o(irq_out_n_o), .clk_link_i(clk_link_i),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// *** verif/host_bus_model.sv ***
// host-side two-wire bus master model that reaches the block's registers
`timescale 1ns/1ns
module host_bus_model (
    // bus wires; sda is only pulled low, the pull-up gives the high level
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // data moves 300 ns after scl falls, so no false start can be seen
    task automatic bit_io(input logic b, output logic r);
        #300 sda_low_o = ~b;
        #1000 scl_o = 1'b1;
        #350 r = sda_i;
        #350 scl_o = 1'b0;
    endtask
    // start or repeated start, and stop, at the bus minimum spacing
    task automatic start_cond();
        #300 sda_low_o = 1'b0;
        #1000 scl_o = 1'b1;
        #700 sda_low_o = 1'b1;
        #700 scl_o = 1'b0;
    endtask
    task automatic stop_cond();
        #300 sda_low_o = 1'b1;
        #1000 scl_o = 1'b1;
        #700 sda_low_o = 1'b0;
        #1300;
    endtask
    // byte msb first plus ninth clock; sending ff releases the line to read
    task automatic xfer(input logic [7:0] v, output logic [7:0] got, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
            got[i] = r;
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] idx,
                             input logic [7:0] d, output logic ok);
        logic [7:0] g;
        logic a0, a1, a2;
        start_cond();
        xfer({dev, 1'b0}, g, a0);
        xfer(idx, g, a1);
        xfer(d, g, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
    // index written first, then repeated start, read address, one byte, nack
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] idx,
                            output logic [7:0] d, output logic ok);
        logic [7:0] g;
        logic a0, a1, a2, nack;
        start_cond();
        xfer({dev, 1'b0}, g, a0);
        xfer(idx, g, a1);
        start_cond();
        xfer({dev, 1'b1}, g, a2);
        xfer(8'hff, d, nack);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule  // host_bus_model

// *** verif/testbench.sv ***
// self-checking bench for the touch-key block driven through the bus host
`timescale 1ns/1ns
module testbench;
    localparam logic [19:0] SHORT = 20'd40;
    localparam logic [19:0] LONG  = 20'd100;
    // bus address follows the strap, which changes across the mid-run reset
    logic [6:0]  dev = {touch_key_pkg::BUS_ADDR_HI, 2'h2};
    logic       clk_sys_i = 1'b0;
    logic       clk_link_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       hw_shutdown_n_i = 1'b1;
    logic [7:0] touch_raw_i = 8'h00;
    logic       scl, host_low, sda_o, sda_oe_o, sleep_o, irq_out_n_o, ok;
    logic [1:0] sense_sel_o;
    logic [7:0] chan_out_o, chan_oe_o;
    logic [15:0] t;
    int         failures = 0;
    int         n_tests = 0;
    int         cnt;
    // rows: enables, touch level, expected pressed, expected change flags
    logic [31:0] rows [5] = '{32'hff010101, 32'hff818180, 32'h7f810180, 32'h7f000001,
                              32'hff3c3c3c};
    logic [7:0]  rst_exp [6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    wire sda = ~(host_low | sda_oe_o);  // pulled up, either side may sink it
    always #20 clk_sys_i = ~clk_sys_i;
    always #15 clk_link_i = ~clk_link_i;
    // short auto-clear spans keep the run brief
    touch_key_status_interrupt #(.AUTOCLR_SHORT_CYC(SHORT), .AUTOCLR_LONG_CYC(LONG))
    i_touch_key_status_interrupt (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_link_i(clk_link_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(dev[1:0]),
        .touch_raw_i(touch_raw_i), .hw_shutdown_n_i(hw_shutdown_n_i),
        .sense_sel_o(sense_sel_o), .sleep_o(sleep_o), .chan_out_o(chan_out_o),
        .chan_oe_o(chan_oe_o), .irq_out_n_o(irq_out_n_o));
    host_bus_model i_host_bus_model (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        i_host_bus_model.write_reg(dev, idx, d, ok);
        check("write ack", 16'h1, {15'h0, ok});
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
        logic [7:0] v;
        i_host_bus_model.read_reg(dev, idx, v, ok);
        check("read ack", 16'h1, {15'h0, ok});
        check(name, {8'h0, exp}, {8'h0, v});
    endtask
    // inputs move 2 ns after a rising edge, except the shutdown pin set right after a bus write
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a hang is cut off well past the expected run length
    initial begin
        #4_000_000;
        failures++;
        $display("unexpected watchdog expected done seen timeout");
        summarize();
    end
    initial begin
        cyc(8);  // longer than four cycles so the link side sees the reset
        reset_i = 1'b0;
        cyc(20);
        for (int k = 0; k < 5; k++) begin
            wr(8'h01, rows[k][31:24]);
            cyc(1);
            touch_raw_i = rows[k][23:16];
            cyc(12);
            check("sinks", {8'h0, rows[k][15:8]}, {8'h0, chan_oe_o});
            check("irq", {15'h0, rows[k][7:0] == 8'h0}, {15'h0, irq_out_n_o});
            rd(8'h02, rows[k][15:8], "pressed");
            rd(8'h03, rows[k][7:0], "change");
            cyc(1);
            check("irq read", 16'h1, {15'h0, irq_out_n_o});
            $display("table row %0d done", k);
        end
        for (int s = 0; s < 3; s++) begin
            wr(8'h00, {1'b0, 2'(s), 5'h00});
            cyc(1);
            check("sense", 16'(s), {14'h0, sense_sel_o});
        end
        rd(8'h00, 8'h40, "config");
        $display("sensitivity tests done");
        wr(8'h00, 8'h80);
        cyc(6);
        check("soft sleep", 16'h1, {15'h0, sleep_o});
        touch_raw_i = 8'h00;
        cyc(12);
        check("frozen", 16'h3c, {8'h0, chan_oe_o});
        rd(8'h01, 8'hff, "kept");
        cyc(1);
        touch_raw_i = 8'h3c;
        cyc(12);
        wr(8'h00, 8'h00);
        hw_shutdown_n_i = 1'b0;
        cyc(8);
        check("pin sleep", 16'h1, {15'h0, sleep_o});
        touch_raw_i = 8'h00;
        wr(8'h01, 8'h0f);
        check("frozen pin", 16'h3c, {8'h0, chan_oe_o});
        rd(8'h01, 8'hff, "write dropped");
        cyc(1);
        touch_raw_i = 8'h3c;
        hw_shutdown_n_i = 1'b1;
        cyc(12);
        check("awake", 16'h0, {15'h0, sleep_o});
        $display("shutdown tests done");
        // codes 01, 10, 11; 11 behaves as off and holds until read
        for (int c = 1; c < 4; c++) begin
            wr(8'h04, {2'(c), 6'h00});
            cyc(1);
            touch_raw_i = touch_raw_i ^ 8'h01;
            t = (c == 1) ? 16'(SHORT) + 16'd4 : (c == 2) ? 16'(LONG) + 16'd4 : 16'd400;
            cnt = 0;
            while ((cnt < 8 || irq_out_n_o === 1'b0) && cnt < 400) begin
                cyc(1);
                cnt++;
            end
            check("autoclear", t, (cnt + 2 >= t && cnt <= t + 2) ? t : 16'(cnt));
            rd(8'h03, 8'h01, "change");
            cyc(1);
            check("irq read", 16'h1, {15'h0, irq_out_n_o});
        end
        i_host_bus_model.write_reg({touch_key_pkg::BUS_ADDR_HI, 2'h1}, 8'h01, 8'h00, ok);
        check("foreign ack", 16'h0, {15'h0, ok});
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h3d, "read only");
        rd(8'h01, 8'hff, "foreign dropped");
        $display("auto-clear and bus tests done");
        wr(8'h00, 8'h40);
        cyc(1);
        touch_raw_i = 8'h00;
        cyc(12);
        reset_i = 1'b1;
        // new strap is caught during reset; later reads only ack if it took
        dev = {touch_key_pkg::BUS_ADDR_HI, 2'h1};
        cyc(8);
        reset_i = 1'b0;
        cyc(20);
        check("irq reset", 16'h1, {15'h0, irq_out_n_o});
        check("sinks reset", 16'h0, {8'h0, chan_oe_o});
        for (int i = 0; i < 6; i++) begin
            rd(8'(i), rst_exp[i], "reset value");
        end
        $display("reset test done");
        summarize();
    end
endmodule  // testbench
